//--- common/scz_defines.vh
`ifndef SCZ_DEFINES_VH
`define SCZ_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define SCZ_IDX_PWR 10'h087
`define SCZ_IDX_CTL 10'h098
`define SCZ_IDX_BUF 10'h099
`define SCZ_IDX_CVT 10'h0D8
`define SCZ_ADDR_PWR 12'h21C
`define SCZ_ADDR_CTL 12'h260
`define SCZ_ADDR_BUF 12'h264
`define SCZ_ADDR_CVT 12'h360

// Field positions
`define SCZ_PWR_DOUBLE 7
`define SCZ_CVT_BDSEL 7
`define SCZ_CTL_MODE_HI 7
`define SCZ_CTL_MODE_LO 6
`define SCZ_CTL_MPE 5
`define SCZ_CTL_REN 4
`define SCZ_CTL_TX9 3
`define SCZ_CTL_RX9 2
`define SCZ_CTL_TXDONE 1
`define SCZ_CTL_RXDONE 0

// Reset values
`define SCZ_PWR_RST 8'h00
`define SCZ_CTL_RST 8'h00
`define SCZ_CVT_RST 8'h00

// Mode encodings of the two mode select bits
`define SCZ_MODE_SHIFT 2'h0
`define SCZ_MODE_UART8 2'h1
`define SCZ_MODE_UART9F 2'h2
`define SCZ_MODE_UART9V 2'h3

// Timing counts; the shift mode ones are in oscillator (pclk) cycles
`define SCZ_M0_DIV 4'hC
`define SCZ_M0_LAST 4'hB
`define SCZ_M0_HALF 4'h6
`define SCZ_BD_DIV 12'h9A5
`define SCZ_BD_STEP 12'h010
`define SCZ_OVS_LAST 4'hF
`define SCZ_OVS_MID 4'h7
`define SCZ_LAST_BIT10 4'h9
`define SCZ_LAST_BIT11 4'hA

`endif

//--- verilog/scz_uart.v
// Contract
// - Shift mode moves eight bits LSB first on rx pin; tx pin gives clock.
// - Shift mode bit rate is oscillator divided by twelve, ignoring baud settings.
// - Mode 1 frame is start low, eight data LSB first, stop high.
// - Mode 1 receive stores stop bit into rx ninth bit; unused in shift mode.
// - Modes 2 and 3 send start, eight data, tx ninth bit, stop.
// - Modes 2 and 3 store received ninth bit; stop bit is not checked.
// - Two mode select bits pick shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// - Any write of the data buffer loads transmitter and starts sending.
// - Reading data buffer returns the separate receive register.
// - Shift mode reception starts when rx done is 0 and receiver enabled.
// - Async reception starts on start bit edge only while receiver enabled.
// - Tx done set after eighth bit in shift mode, at stop start otherwise.
// - Rx done set after eighth bit in shift mode, during stop otherwise.
// - Modes 2/3 with multiproc enable skip rx done when ninth bit is 0.
// - Mode 1 with multiproc enable sets rx done only on valid stop bit.
// - Async modes use a sixteen times oversampling clock divided by sixteen.
// - Mode 2 rate is oscillator/64, or /32 with double rate; reset to 0.
// - Double rate bit, bit 7 of power control, doubles rate in modes 1-3.
// - With baud generator select, modes 1/3 rate is osc times 2^double over 2469.
// - Timer 1 source gives overflow rate times 2^double divided by 32.
// - Receiver double buffered; new byte dropped while rx done is still set.
// - Transmitter and receiver run independently at the same time in modes 1 to 3; shift mode shares one engine.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "scz_defines.vh"

module scz_uart (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Baud source from timer 1
  input wire timer1_ovf,
  // Serial pins
  input wire rx_pin_in,
  output wire rx_pin_out,
  output wire rx_pin_oe,
  output wire tx_pin
);

  // Software visible registers
  reg [7:0] pwr_r;
  reg [7:0] cvt_r;
  reg [7:0] ctl_r;
  reg [7:0] rx_buf_r;
  reg [7:0] ctl_nxt;

  // Baud tick generation
  reg [1:0] m2_cnt_r;
  reg [11:0] bd_acc_r;
  reg t1_half_r;
  reg ovs_tick;
  wire [12:0] bd_sum;

  // Shift mode engine
  reg m0_busy_r;
  reg m0_rx_r;
  reg [3:0] m0_cnt_r;
  reg [2:0] m0_bit_r;
  reg [7:0] m0_sh_r;

  // Async transmitter
  reg tx_busy_r;
  reg [3:0] tx_idx_r;
  reg [3:0] tx_tc_r;
  reg [9:0] tx_sh_r;
  reg tx_line_r;

  // Async receiver
  reg rx_busy_r;
  reg [3:0] rx_idx_r;
  reg [3:0] rx_tc_r;
  reg [8:0] rx_sh_r;
  reg rx_prev_r;

  wire [1:0] mode;
  wire is_async;
  wire dbl;
  wire mpe;
  wire ren;
  wire wr_en;
  wire wr_ctl;
  wire wr_buf;
  wire [3:0] tx_last;
  wire [3:0] rx_last;
  wire m0_end;
  wire tx_step;
  wire rx_mid;
  wire rx_step;
  wire [7:0] rx_data;
  wire rx_keep;
  wire rx_ok;
  wire m0_rx_start;
  wire tx_done_set;
  wire rx_done_set;
  wire rx9_set;
  wire rx9_val;

  assign mode = {ctl_r[`SCZ_CTL_MODE_HI], ctl_r[`SCZ_CTL_MODE_LO]};
  assign is_async = (mode != `SCZ_MODE_SHIFT);
  assign dbl = pwr_r[`SCZ_PWR_DOUBLE];
  assign mpe = ctl_r[`SCZ_CTL_MPE];
  assign ren = ctl_r[`SCZ_CTL_REN];

  // Bus decode, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign wr_ctl = wr_en & (paddr == `SCZ_ADDR_CTL);
  assign wr_buf = wr_en & (paddr == `SCZ_ADDR_BUF);
  assign pslverr = psel & penable & (paddr != `SCZ_ADDR_PWR) & (paddr != `SCZ_ADDR_CTL) &
                   (paddr != `SCZ_ADDR_BUF) & (paddr != `SCZ_ADDR_CVT);

  // Read mux; buffer read shows receive register only
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `SCZ_ADDR_PWR: prdata = {24'h00_0000, pwr_r};
      `SCZ_ADDR_CTL: prdata = {24'h00_0000, ctl_r};
      `SCZ_ADDR_BUF: prdata = {24'h00_0000, rx_buf_r};
      `SCZ_ADDR_CVT: prdata = {24'h00_0000, cvt_r};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Plain configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= `SCZ_PWR_RST;
      cvt_r <= `SCZ_CVT_RST;
    end else begin
      if (wr_en && paddr == `SCZ_ADDR_PWR)
        pwr_r <= pwdata[7:0];
      if (wr_en && paddr == `SCZ_ADDR_CVT)
        cvt_r <= pwdata[7:0];
    end
  end

  // Oversampling tick: sixteen per bit time in async modes
  assign bd_sum = {1'b0, bd_acc_r} + (dbl ? {`SCZ_BD_STEP, 1'b0} : {1'b0, `SCZ_BD_STEP});
  always @* begin
    ovs_tick = 1'b0;
    if (mode == `SCZ_MODE_UART9F)
      ovs_tick = dbl ? m2_cnt_r[0] : (m2_cnt_r == 2'h3);
    else if (mode != `SCZ_MODE_SHIFT && cvt_r[`SCZ_CVT_BDSEL])
      ovs_tick = (bd_sum >= {1'b0, `SCZ_BD_DIV});
    else if (mode != `SCZ_MODE_SHIFT)
      ovs_tick = timer1_ovf & (dbl | t1_half_r);
  end

  // Divider state for all three rate sources
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m2_cnt_r <= 2'h0;
      bd_acc_r <= 12'h000;
      t1_half_r <= 1'b0;
    end else begin
      m2_cnt_r <= m2_cnt_r + 2'h1;
      if (bd_sum >= {1'b0, `SCZ_BD_DIV})
        bd_acc_r <= bd_sum[11:0] - `SCZ_BD_DIV;
      else
        bd_acc_r <= bd_sum[11:0];
      if (timer1_ovf)
        t1_half_r <= ~t1_half_r;
    end
  end

  // Shift mode: twelve clocks per bit, clock low then high
  assign m0_end = m0_busy_r & (m0_cnt_r == `SCZ_M0_LAST) & (m0_bit_r == 3'h7);
  assign m0_rx_start = ~is_async & ~m0_busy_r & ~wr_buf & ren & ~ctl_r[`SCZ_CTL_RXDONE];
  assign rx_pin_out = m0_sh_r[0];
  assign rx_pin_oe = m0_busy_r & ~m0_rx_r;
  assign tx_pin = m0_busy_r ? (m0_cnt_r >= `SCZ_M0_HALF) : tx_line_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_busy_r <= 1'b0;
      m0_rx_r <= 1'b0;
      m0_cnt_r <= 4'h0;
      m0_bit_r <= 3'h0;
      m0_sh_r <= 8'hFF;
    end else if (wr_buf && !is_async) begin
      m0_busy_r <= 1'b1;
      m0_rx_r <= 1'b0;
      m0_cnt_r <= 4'h0;
      m0_bit_r <= 3'h0;
      m0_sh_r <= pwdata[7:0];
    end else if (m0_rx_start) begin
      m0_busy_r <= 1'b1;
      m0_rx_r <= 1'b1;
      m0_cnt_r <= 4'h0;
      m0_bit_r <= 3'h0;
    end else if (m0_busy_r) begin
      if (m0_cnt_r == `SCZ_M0_LAST) begin
        m0_cnt_r <= 4'h0;
        m0_bit_r <= m0_bit_r + 3'h1;
        if (!m0_rx_r)
          m0_sh_r <= {1'b1, m0_sh_r[7:1]};
        if (m0_bit_r == 3'h7)
          m0_busy_r <= 1'b0;
      end else begin
        m0_cnt_r <= m0_cnt_r + 4'h1;
      end
      if (m0_rx_r && m0_cnt_r == `SCZ_M0_HALF)
        m0_sh_r <= {rx_pin_in, m0_sh_r[7:1]};
    end
  end

  // Async transmitter, paced by the oversampling tick
  assign tx_last = (mode == `SCZ_MODE_UART8) ? `SCZ_LAST_BIT10 : `SCZ_LAST_BIT11;
  assign tx_step = tx_busy_r & ovs_tick & (tx_tc_r == `SCZ_OVS_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_r <= 1'b0;
      tx_idx_r <= 4'h0;
      tx_tc_r <= 4'h0;
      tx_sh_r <= 10'h3FF;
      tx_line_r <= 1'b1;
    end else if (wr_buf && is_async) begin
      tx_busy_r <= 1'b1;
      tx_idx_r <= 4'h0;
      tx_tc_r <= 4'h0;
      tx_line_r <= 1'b0;
      if (mode == `SCZ_MODE_UART8)
        tx_sh_r <= {2'h3, pwdata[7:0]};
      else
        tx_sh_r <= {1'b1, ctl_r[`SCZ_CTL_TX9], pwdata[7:0]};
    end else if (tx_busy_r && ovs_tick) begin
      tx_tc_r <= tx_tc_r + 4'h1;
      if (tx_step) begin
        if (tx_idx_r == tx_last) begin
          tx_busy_r <= 1'b0;
          tx_line_r <= 1'b1;
        end else begin
          tx_idx_r <= tx_idx_r + 4'h1;
          tx_line_r <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        end
      end
    end
  end

  // Async receiver: start edge, mid-bit sampling
  assign rx_last = (mode == `SCZ_MODE_UART8) ? `SCZ_LAST_BIT10 : `SCZ_LAST_BIT11;
  assign rx_mid = rx_busy_r & ovs_tick & (rx_tc_r == `SCZ_OVS_MID);
  assign rx_step = rx_busy_r & ovs_tick & (rx_tc_r == `SCZ_OVS_LAST);
  assign rx_data = (mode == `SCZ_MODE_UART8) ? rx_sh_r[8:1] : rx_sh_r[7:0];
  assign rx_ok = (mode == `SCZ_MODE_UART8) ? (~mpe | rx_pin_in) : (~mpe | rx_sh_r[8]);
  assign rx_keep = rx_mid & (rx_idx_r == rx_last) & rx_ok & ~ctl_r[`SCZ_CTL_RXDONE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_tc_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_pin_in;
      if (!rx_busy_r) begin
        if (is_async && ren && rx_prev_r && !rx_pin_in) begin
          rx_busy_r <= 1'b1;
          rx_idx_r <= 4'h0;
          rx_tc_r <= 4'h0;
        end
      end else if (ovs_tick) begin
        rx_tc_r <= rx_tc_r + 4'h1;
        if (rx_step)
          rx_idx_r <= rx_idx_r + 4'h1;
        if (rx_mid) begin
          if (rx_idx_r == 4'h0 && rx_pin_in)
            rx_busy_r <= 1'b0;
          else if (rx_idx_r == rx_last)
            rx_busy_r <= 1'b0;
          else if (rx_idx_r != 4'h0)
            rx_sh_r <= {rx_pin_in, rx_sh_r[8:1]};
        end
      end
    end
  end

  // Receive holding register, separate from the shifter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_buf_r <= 8'h00;
    else if (rx_keep)
      rx_buf_r <= rx_data;
    else if (m0_end && m0_rx_r && !ctl_r[`SCZ_CTL_RXDONE])
      rx_buf_r <= m0_sh_r;
  end

  // Hardware flag events
  assign tx_done_set = (m0_end & ~m0_rx_r) | (tx_step & (tx_idx_r + 4'h1 == tx_last));
  assign rx_done_set = rx_keep | (m0_end & m0_rx_r);
  assign rx9_set = rx_keep;
  assign rx9_val = (mode == `SCZ_MODE_UART8) ? rx_pin_in : rx_sh_r[8];

  // Control register: hardware set wins over software write
  always @* begin
    ctl_nxt = ctl_r;
    if (wr_ctl)
      ctl_nxt = pwdata[7:0];
    if (tx_done_set)
      ctl_nxt[`SCZ_CTL_TXDONE] = 1'b1;
    if (rx_done_set)
      ctl_nxt[`SCZ_CTL_RXDONE] = 1'b1;
    if (rx9_set)
      ctl_nxt[`SCZ_CTL_RX9] = rx9_val;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctl_r <= `SCZ_CTL_RST;
    else
      ctl_r <= ctl_nxt;
  end

endmodule // scz_uart

//--- tb/scz_uart_asserts.sv
`timescale 1ns/10ps
`include "scz_defines.vh"
module scz_chk (
  // APB side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Serial side
  input wire timer1_ovf,
  input wire rx_pin_in,
  input wire rx_pin_out,
  input wire rx_pin_oe,
  input wire tx_pin
);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire wr = acc && pwrite;
  wire hit = paddr == `SCZ_ADDR_PWR || paddr == `SCZ_ADDR_CTL || paddr == `SCZ_ADDR_BUF || paddr == `SCZ_ADDR_CVT;
  reg [1:0] mode_r;
  reg dbl_r;
  reg bd_r;
  // Shadow of software-written fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 2'h0;
      dbl_r <= 1'b0;
      bd_r <= 1'b0;
    end else if (wr) begin
      if (paddr == `SCZ_ADDR_CTL) mode_r <= pwdata[7:6];
      if (paddr == `SCZ_ADDR_PWR) dbl_r <= pwdata[7];
      if (paddr == `SCZ_ADDR_CVT) bd_r <= pwdata[7];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && hit |-> !pslverr) else $error("mapped access refused");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_mode_rdback: assert property (rd && paddr == `SCZ_ADDR_CTL |-> prdata[7:6] == mode_r)
    else $error("mode field lost");
  a_double_rdback: assert property (rd && paddr == `SCZ_ADDR_PWR |-> prdata[7] == dbl_r)
    else $error("double rate bit lost");
  a_bdsel_rdback: assert property (rd && paddr == `SCZ_ADDR_CVT |-> prdata[7] == bd_r)
    else $error("baud select bit lost");
  a_oe_shift_only: assert property (mode_r != 2'h0 |-> !rx_pin_oe) else $error("rx pin driven");
  a_shift_clk: assert property ($fell(tx_pin) && mode_r == 2'h0 |-> !tx_pin [*6] ##1 tx_pin)
    else $error("shift clock low phase wrong");
  a_shift_hold: assert property ($rose(tx_pin) && rx_pin_oe |-> $stable(rx_pin_out))
    else $error("shift data moved");
  a_tx_start: assert property (wr && paddr == `SCZ_ADDR_BUF && mode_r != 2'h0 |-> ##[1:2] !tx_pin)
    else $error("no start bit");
  cover property (rx_pin_oe && $rose(tx_pin));
  cover property (acc && !hit);
  cover property ($fell(tx_pin) && mode_r == 2'h3);
endmodule // scz_chk

bind scz_uart scz_chk scz_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1_ovf(timer1_ovf), .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin));

//--- tb/scz_remote.sv
`timescale 1ns/10ps
module scz_remote (
  // Serial lines
  input wire pclk,
  input wire tx_pin,
  output reg rx_line
);
  initial rx_line = 1'b1;
  // Send one frame, start low, data LSB first, stop high
  task automatic send(input [8:0] v, input integer nb, input integer bp);
    reg [10:0] f;
    integer k;
    begin
      f = (nb == 10) ? {2'b11, v[7:0], 1'b0} : {1'b1, v, 1'b0};
      for (k = 0; k < nb; k = k + 1) begin
        rx_line <= f[k];
        repeat (bp) @(posedge pclk);
      end
      rx_line <= 1'b1;
    end
  endtask
  // Shift register far end: next bit after each falling shift clock
  task automatic shift_out(input [7:0] v);
    integer k, j;
    begin
      for (j = 0; j < 24 && tx_pin !== 1'b0; j = j + 1) @(posedge pclk);
      for (k = 0; k < 8; k = k + 1) begin
        rx_line <= v[k];
        for (j = 0; j < 24 && tx_pin !== 1'b1; j = j + 1) @(posedge pclk);
        for (j = 0; j < 24 && tx_pin !== 1'b0; j = j + 1) @(posedge pclk);
      end
      rx_line <= 1'b1;
    end
  endtask
  // Capture one frame, sampled mid-bit
  task automatic grab(input integer nb, input integer bp, output reg [10:0] f);
    integer k;
    begin
      f = 11'h000;
      for (k = 0; k < 20000 && tx_pin !== 1'b0; k = k + 1) @(posedge pclk);
      repeat (bp / 2) @(posedge pclk);
      for (k = 0; k < nb; k = k + 1) begin
        f[k] = tx_pin;
        repeat (bp) @(posedge pclk);
      end
    end
  endtask
endmodule // scz_remote

//--- tb/tb_scz_uart.sv
`timescale 1ns/10ps
`include "scz_defines.vh"
module tb_scz_uart;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [1:0] ovf_cnt = 2'h0;
  reg timer1_ovf = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, rx_pin_out, rx_pin_oe, tx_pin, rx_line;
  wire rx_wire = rx_pin_oe ? rx_pin_out : rx_line;
  integer seed = 32'h7B8A6622;
  integer n_errors = 0;
  integer checked = 0;
  integer m, nb, bp, k;
  reg [31:0] rd;
  reg err;
  reg [10:0] fr;
  reg [8:0] v, u;

  always #2.5 pclk = ~pclk;
  // Timer 1 overflow every fourth clock, as an auto-reload timer would give
  always @(posedge pclk) begin
    ovf_cnt <= ovf_cnt + 2'h1;
    timer1_ovf <= &ovf_cnt;
  end

  scz_uart scz_uart_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .rx_pin_in(rx_wire), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin));
  scz_remote scz_remote_inst (.pclk(pclk), .tx_pin(tx_pin), .rx_line(rx_line));

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask

  // One APB transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
        @(posedge pclk);
        i = i + 1;
      end while (pready !== 1'b1 && i < 100);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 100) begin
        n_errors = n_errors + 1;
        wrap_up;
      end
    end
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    apb(0, `SCZ_ADDR_PWR, 0);
    chk("pwr", rd, 32'h0);
    apb(0, `SCZ_ADDR_CVT, 0);
    chk("cvt", rd, 32'h0);
    apb(0, 12'h000, 0);
    chk("slverr", err, 1);
    $display("test reset done");
    // Modes 1 to 3 at double rate, send and receive at once
    apb(1, `SCZ_ADDR_PWR, 32'h80);
    for (m = 1; m < 4; m = m + 1) begin
      nb = (m == 1) ? 10 : 11;
      bp = (m == 2) ? 32 : 64;
      v = $random(seed);
      u = $random(seed);
      apb(1, `SCZ_ADDR_CTL, {24'h0, m[1:0], 2'b01, v[8], 3'h0});
      fork
        scz_remote_inst.grab(nb, bp, fr);
        apb(1, `SCZ_ADDR_BUF, {24'h0, v[7:0]});
        scz_remote_inst.send(u, nb, bp);
      join
      chk("frame", fr, (nb == 10) ? {2'b01, v[7:0], 1'b0} : {1'b1, v[8], v[7:0], 1'b0});
      apb(0, `SCZ_ADDR_CTL, 0);
      chk("ctl", rd, {24'h0, m[1:0], 2'b01, v[8], (m == 1) ? 1'b1 : u[8], 2'b11});
      apb(0, `SCZ_ADDR_BUF, 0);
      chk("rx byte", rd, {24'h0, u[7:0]});
    end
    // Mode 1 paced by the dedicated divider at double rate
    apb(1, `SCZ_ADDR_CVT, 32'h80);
    apb(1, `SCZ_ADDR_CTL, 32'h50);
    v = $random(seed);
    u = $random(seed);
    fork
      scz_remote_inst.grab(10, 1234, fr);
      apb(1, `SCZ_ADDR_BUF, {24'h0, v[7:0]});
      scz_remote_inst.send(u, 10, 1234);
    join
    chk("gen frame", fr, {2'b01, v[7:0], 1'b0});
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("gen ctl", rd, 32'h57);
    apb(0, `SCZ_ADDR_BUF, 0);
    chk("gen byte", rd, {24'h0, u[7:0]});
    apb(1, `SCZ_ADDR_CVT, 32'h00);
    $display("test async done");
    // Address filter, then a frame lost to an unread byte
    apb(1, `SCZ_ADDR_CTL, 32'hF0);
    scz_remote_inst.send({1'b0, u[7:0]}, 11, 64);
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("filtered", rd, 32'hF0);
    scz_remote_inst.send({1'b1, u[7:0]}, 11, 64);
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("address", rd, 32'hF5);
    scz_remote_inst.send({1'b1, ~u[7:0]}, 11, 64);
    apb(0, `SCZ_ADDR_BUF, 0);
    chk("overrun", rd, {24'h0, u[7:0]});
    // Mode 1 stop bit check with multiprocessor enable
    apb(1, `SCZ_ADDR_CTL, 32'h70);
    scz_remote_inst.send({1'b0, u[7:0]}, 11, 64);
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("bad stop", rd, 32'h70);
    scz_remote_inst.send({1'b1, ~u[7:0]}, 10, 64);
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("good stop", rd, 32'h75);
    apb(0, `SCZ_ADDR_BUF, 0);
    chk("stop byte", rd, {24'h0, ~u[7:0]});
    $display("test filter done");
    // Shift mode transmit, twelve clocks a bit
    apb(1, `SCZ_ADDR_CTL, 32'h00);
    v = $random(seed);
    apb(1, `SCZ_ADDR_BUF, {24'h0, v[7:0]});
    for (k = 0; k < 20 && rx_pin_oe !== 1'b1; k = k + 1) @(posedge pclk);
    for (k = 0; k < 8; k = k + 1) begin
      chk("shift bit", rx_pin_out, v[k]);
      repeat (12) @(posedge pclk);
    end
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("shift flags", rd[1:0], 2'b10);
    // Shift mode receive, started by enabling with done clear
    v = $random(seed);
    apb(1, `SCZ_ADDR_CTL, 32'h10);
    scz_remote_inst.shift_out(v[7:0]);
    apb(0, `SCZ_ADDR_CTL, 0);
    chk("shift rx flags", rd, 32'h11);
    apb(0, `SCZ_ADDR_BUF, 0);
    chk("shift rx byte", rd, {24'h0, v[7:0]});
    $display("test shift done");
    wrap_up;
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors = n_errors + 1;
    wrap_up;
  end
endmodule // tb_scz_uart
